/* inc/ppb_regs.svh */
`ifndef PPB_REGS_SVH
`define PPB_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PPB_RT_DATA_OFS     12'h000
`define PPB_RT_CTRL_OFS     12'h004
`define PPB_IN2_DATA_OFS    12'h008
`define PPB_IN2_PU_OFS      12'h00C
`define PPB_P3_DATA_OFS     12'h010
`define PPB_P3_DIR_OFS      12'h014
`define PPB_P3_PU_OFS       12'h018
`define PPB_P4_DATA_OFS     12'h01C
`define PPB_P4_CTRL_OFS     12'h020
`define PPB_P5_DATA_OFS     12'h024
`define PPB_P5_DIR_OFS      12'h028
`define PPB_P5_PU_OFS       12'h02C
`define PPB_P6_DATA_OFS     12'h030
`define PPB_P6_DIR_OFS      12'h034
`define PPB_P6_PU_OFS       12'h038
`define PPB_IN7_DATA_OFS    12'h03C
`define PPB_STATUS_OFS      12'h040

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PPB_RT_OE_BIT       0
`define PPB_RT_LOW_EN_BIT   1
`define PPB_RT_HIGH_EN_BIT  2
`define PPB_P4_OUT_BIT      0
`define PPB_P4_PU_BIT       1
`define PPB_STAT_NMI_BIT    0
`define PPB_STAT_ROMLESS_BIT 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PPB_DATA_RST        8'h00
`define PPB_DIR_RST         8'h00
`define PPB_PU_RST          8'h00
`define PPB_CTRL_RST        8'h00

`endif

/* inc/ppb_pkg.sv */
package ppb_pkg;

	typedef logic [7:0]  ppb_byte_t;
	typedef logic [11:0] ppb_addr_t;

	// ----------------------------------------------------------------
	// register select decoded from the bus address
	// ----------------------------------------------------------------
	typedef enum logic [4:0]
	{
		PPB_SEL_NONE    = 5'h00,
		PPB_SEL_RT_DATA = 5'h01,
		PPB_SEL_RT_CTRL = 5'h02,
		PPB_SEL_IN2     = 5'h03,
		PPB_SEL_IN2_PU  = 5'h04,
		PPB_SEL_P3_DATA = 5'h05,
		PPB_SEL_P3_DIR  = 5'h06,
		PPB_SEL_P3_PU   = 5'h07,
		PPB_SEL_P4_DATA = 5'h08,
		PPB_SEL_P4_CTRL = 5'h09,
		PPB_SEL_P5_DATA = 5'h0A,
		PPB_SEL_P5_DIR  = 5'h0B,
		PPB_SEL_P5_PU   = 5'h0C,
		PPB_SEL_P6_DATA = 5'h0D,
		PPB_SEL_P6_DIR  = 5'h0E,
		PPB_SEL_P6_PU   = 5'h0F,
		PPB_SEL_IN7     = 5'h10,
		PPB_SEL_STATUS  = 5'h11
	} ppb_sel_t;

endpackage

/* rtl/ppb_sync.sv */
// two-stage synchroniser for a bus of pin levels
module ppb_sync
#(
	parameter int WIDTH = 8
)
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_one;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			stage_one <= '0;
			sync_out  <= '0;
		end
		else
		begin
			stage_one <= async_in;
			sync_out  <= stage_one;
		end
	end

endmodule // ppb_sync

/* rtl/ppb_bidir_port.sv */
`include "ppb_regs.svh"

// one 8-bit port: latch, per-bit direction, per-bit pull-up enable
module ppb_bidir_port
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// register writes
	input  wire logic              wr_data,
	input  wire logic              wr_dir,
	input  wire logic              wr_pu,
	input  wire ppb_pkg::ppb_byte_t wdata,
	// masks fixing what the port can do
	input  wire ppb_pkg::ppb_byte_t out_only,
	input  wire ppb_pkg::ppb_byte_t avail,
	// pins
	input  wire ppb_pkg::ppb_byte_t pin_sync,
	output ppb_pkg::ppb_byte_t      pin_out,
	output ppb_pkg::ppb_byte_t      pin_oe,
	output ppb_pkg::ppb_byte_t      pull_en,
	// software view
	output ppb_pkg::ppb_byte_t      latch,
	output ppb_pkg::ppb_byte_t      dir,
	output ppb_pkg::ppb_byte_t      pu,
	output ppb_pkg::ppb_byte_t      rd_value
);
	import ppb_pkg::*;

	ppb_byte_t eff_out;

	// latch is written whatever the direction
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			latch <= `PPB_DATA_RST;
			dir   <= `PPB_DIR_RST;
			pu    <= `PPB_PU_RST;
		end
		else
		begin
			if (wr_data)
				latch <= wdata;
			if (wr_dir)
				dir <= wdata;
			if (wr_pu)
				pu <= wdata;
		end
	end

	// unavailable bits never drive and never pull
	assign eff_out  = (dir | out_only) & avail;
	assign pin_out  = latch & eff_out;
	assign pin_oe   = eff_out;
	assign pull_en  = pu & ~eff_out & avail;
	// pin level for inputs, latch for outputs
	assign rd_value = ((latch & eff_out) | (pin_sync & ~eff_out)) & avail;

endmodule // ppb_bidir_port

/* rtl/ppb_port_bank.sv */
// Local design decisions: the register addresses and register access over APB.
`include "ppb_regs.svh"

module ppb_port_bank
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               sys_rst,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire ppb_pkg::ppb_addr_t paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// variant strap, high for the variant without program memory
	input  wire logic               romless,
	// realtime output triggers, one-cycle pulses from the timer
	input  wire logic               rt_low_trig,
	input  wire logic               rt_high_trig,
	// output-only port
	output ppb_pkg::ppb_byte_t      rt_output_port,
	output ppb_pkg::ppb_byte_t      rt_output_port_oe,
	// input port two
	input  wire ppb_pkg::ppb_byte_t input_port_two,
	output logic [5:0]              upper_six_input_bits_pull_en,
	// bidirectional port three
	input  wire ppb_pkg::ppb_byte_t bidir_port_three_in,
	output ppb_pkg::ppb_byte_t      bidir_port_three_out,
	output ppb_pkg::ppb_byte_t      bidir_port_three_oe,
	output ppb_pkg::ppb_byte_t      bidir_port_three_pull_en,
	// bidirectional port four
	input  wire ppb_pkg::ppb_byte_t bidir_port_four_in,
	output ppb_pkg::ppb_byte_t      bidir_port_four_out,
	output ppb_pkg::ppb_byte_t      bidir_port_four_oe,
	output ppb_pkg::ppb_byte_t      bidir_port_four_pull_en,
	// bidirectional port five
	input  wire ppb_pkg::ppb_byte_t bidir_port_five_in,
	output ppb_pkg::ppb_byte_t      bidir_port_five_out,
	output ppb_pkg::ppb_byte_t      bidir_port_five_oe,
	output ppb_pkg::ppb_byte_t      bidir_port_five_pull_en,
	// mixed port six
	input  wire ppb_pkg::ppb_byte_t mixed_port_six_in,
	output ppb_pkg::ppb_byte_t      mixed_port_six_out,
	output ppb_pkg::ppb_byte_t      mixed_port_six_oe,
	output ppb_pkg::ppb_byte_t      mixed_port_six_pull_en,
	// analog-shared input port
	input  wire logic [5:0]         analog_shared_input_port
);
	import ppb_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	ppb_byte_t  in2_sync;
	ppb_byte_t  p3_sync;
	ppb_byte_t  p4_sync;
	ppb_byte_t  p5_sync;
	ppb_byte_t  p6_sync;
	logic [5:0] in7_sync;

	ppb_sync #(.WIDTH(8)) u_sync_in2 (.clk(clk), .sys_rst(sys_rst),
		.async_in(input_port_two), .sync_out(in2_sync));
	ppb_sync #(.WIDTH(8)) u_sync_p3 (.clk(clk), .sys_rst(sys_rst),
		.async_in(bidir_port_three_in), .sync_out(p3_sync));
	ppb_sync #(.WIDTH(8)) u_sync_p4 (.clk(clk), .sys_rst(sys_rst),
		.async_in(bidir_port_four_in), .sync_out(p4_sync));
	ppb_sync #(.WIDTH(8)) u_sync_p5 (.clk(clk), .sys_rst(sys_rst),
		.async_in(bidir_port_five_in), .sync_out(p5_sync));
	ppb_sync #(.WIDTH(8)) u_sync_p6 (.clk(clk), .sys_rst(sys_rst),
		.async_in(mixed_port_six_in), .sync_out(p6_sync));
	ppb_sync #(.WIDTH(6)) u_sync_in7 (.clk(clk), .sys_rst(sys_rst),
		.async_in(analog_shared_input_port), .sync_out(in7_sync));

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	ppb_sel_t sel;
	logic     wr_en;
	logic     rd_ok;
	logic     ro_reg;

	// byte lane 0 carries all data; other lanes are ignored
	assign wr_en = psel & penable & pwrite & pstrb[0];

	assign sel =
		(paddr == `PPB_RT_DATA_OFS)  ? PPB_SEL_RT_DATA :
		(paddr == `PPB_RT_CTRL_OFS)  ? PPB_SEL_RT_CTRL :
		(paddr == `PPB_IN2_DATA_OFS) ? PPB_SEL_IN2 :
		(paddr == `PPB_IN2_PU_OFS)   ? PPB_SEL_IN2_PU :
		(paddr == `PPB_P3_DATA_OFS)  ? PPB_SEL_P3_DATA :
		(paddr == `PPB_P3_DIR_OFS)   ? PPB_SEL_P3_DIR :
		(paddr == `PPB_P3_PU_OFS)    ? PPB_SEL_P3_PU :
		(paddr == `PPB_P4_DATA_OFS)  ? PPB_SEL_P4_DATA :
		(paddr == `PPB_P4_CTRL_OFS)  ? PPB_SEL_P4_CTRL :
		(paddr == `PPB_P5_DATA_OFS)  ? PPB_SEL_P5_DATA :
		(paddr == `PPB_P5_DIR_OFS)   ? PPB_SEL_P5_DIR :
		(paddr == `PPB_P5_PU_OFS)    ? PPB_SEL_P5_PU :
		(paddr == `PPB_P6_DATA_OFS)  ? PPB_SEL_P6_DATA :
		(paddr == `PPB_P6_DIR_OFS)   ? PPB_SEL_P6_DIR :
		(paddr == `PPB_P6_PU_OFS)    ? PPB_SEL_P6_PU :
		(paddr == `PPB_IN7_DATA_OFS) ? PPB_SEL_IN7 :
		(paddr == `PPB_STATUS_OFS)   ? PPB_SEL_STATUS : PPB_SEL_NONE;

	assign ro_reg = (sel == PPB_SEL_IN2) || (sel == PPB_SEL_IN7) || (sel == PPB_SEL_STATUS);
	assign rd_ok  = (sel != PPB_SEL_NONE);

	// zero-wait slave; unmapped access or write to a read-only word errors
	assign pready  = 1'b1;
	assign pslverr = psel & penable & (~rd_ok | (pwrite & ro_reg));

	// ----------------------------------------------------------------
	// variant strap, synchronised and tracked continuously after reset release
	// ----------------------------------------------------------------
	logic romless_sync;
	logic romless_q;

	ppb_sync #(.WIDTH(1)) u_sync_strap (.clk(clk), .sys_rst(sys_rst),
		.async_in(romless), .sync_out(romless_sync));

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			romless_q <= 1'b0;
		else
			romless_q <= romless_sync;
	end

	// ----------------------------------------------------------------
	// realtime output port
	// ----------------------------------------------------------------
	ppb_byte_t rt_buf;
	ppb_byte_t rt_latch;
	ppb_byte_t rt_ctrl;
	ppb_byte_t next_rt_latch;
	logic      rt_low_rt;
	logic      rt_high_rt;

	assign rt_low_rt  = rt_ctrl[`PPB_RT_LOW_EN_BIT];
	assign rt_high_rt = rt_ctrl[`PPB_RT_HIGH_EN_BIT];

	// each nibble either follows software or loads its buffer on its own trigger
	assign next_rt_latch[3:0] =
		(rt_low_rt && rt_low_trig) ? rt_buf[3:0] :
		(!rt_low_rt && wr_en && sel == PPB_SEL_RT_DATA) ? pwdata[3:0] : rt_latch[3:0];
	assign next_rt_latch[7:4] =
		(rt_high_rt && rt_high_trig) ? rt_buf[7:4] :
		(!rt_high_rt && wr_en && sel == PPB_SEL_RT_DATA) ? pwdata[7:4] : rt_latch[7:4];

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rt_buf   <= `PPB_DATA_RST;
			rt_latch <= `PPB_DATA_RST;
			rt_ctrl  <= `PPB_CTRL_RST;
		end
		else
		begin
			rt_latch <= next_rt_latch;
			if (wr_en && sel == PPB_SEL_RT_DATA)
				rt_buf <= pwdata[7:0];
			if (wr_en && sel == PPB_SEL_RT_CTRL)
				rt_ctrl <= {5'h00, pwdata[2:0]};
		end
	end

	// output-only: all eight bits driven or floated together
	assign rt_output_port    = rt_latch;
	assign rt_output_port_oe = {8{rt_ctrl[`PPB_RT_OE_BIT]}};

	// ----------------------------------------------------------------
	// input port two
	// ----------------------------------------------------------------
	logic in2_pu;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			in2_pu <= 1'b0;
		else if (wr_en && sel == PPB_SEL_IN2_PU)
			in2_pu <= pwdata[0];
	end

	assign upper_six_input_bits_pull_en = {6{in2_pu}};

	// ----------------------------------------------------------------
	// bidirectional ports
	// ----------------------------------------------------------------
	ppb_byte_t p3_latch, p3_dir, p3_pu, p3_rd;
	ppb_byte_t p4_latch, p4_dir, p4_pu, p4_rd;
	ppb_byte_t p5_latch, p5_dir, p5_pu, p5_rd;
	ppb_byte_t p6_latch, p6_dir, p6_pu, p6_rd;
	ppb_byte_t p4_wdata;
	ppb_byte_t p45_avail;
	ppb_byte_t p6_avail;
	logic      p4_ctrl_wr;

	// romless variant: ports four, five and the two strobe bits go away
	assign p45_avail = romless_q ? 8'h00 : 8'hFF;
	assign p6_avail  = romless_q ? 8'hCF : 8'hFF;

	// per-bit direction and per-bit pull-up
	ppb_bidir_port u_port_three (
		.clk(clk), .sys_rst(sys_rst),
		.wr_data(wr_en && sel == PPB_SEL_P3_DATA),
		.wr_dir(wr_en && sel == PPB_SEL_P3_DIR),
		.wr_pu(wr_en && sel == PPB_SEL_P3_PU),
		.wdata(pwdata[7:0]), .out_only(8'h00), .avail(8'hFF),
		.pin_sync(p3_sync), .pin_out(bidir_port_three_out),
		.pin_oe(bidir_port_three_oe), .pull_en(bidir_port_three_pull_en),
		.latch(p3_latch), .dir(p3_dir), .pu(p3_pu), .rd_value(p3_rd));

	// one control word fans out to all eight direction and pull-up bits
	assign p4_ctrl_wr = wr_en && sel == PPB_SEL_P4_CTRL;
	assign p4_wdata   = p4_ctrl_wr ? {8{pwdata[`PPB_P4_OUT_BIT]}} : pwdata[7:0];

	ppb_bidir_port u_port_four (
		.clk(clk), .sys_rst(sys_rst),
		.wr_data(wr_en && sel == PPB_SEL_P4_DATA),
		.wr_dir(p4_ctrl_wr), .wr_pu(1'b0),
		.wdata(p4_wdata), .out_only(8'h00), .avail(p45_avail),
		.pin_sync(p4_sync), .pin_out(bidir_port_four_out),
		.pin_oe(bidir_port_four_oe), .pull_en(),
		.latch(p4_latch), .dir(p4_dir), .pu(), .rd_value(p4_rd));

	logic p4_pu_grp;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			p4_pu_grp <= 1'b0;
		else if (p4_ctrl_wr)
			p4_pu_grp <= pwdata[`PPB_P4_PU_BIT];
	end

	assign p4_pu = {8{p4_pu_grp}};
	// group pull-up only reaches bits in input mode
	assign bidir_port_four_pull_en = p4_pu & ~bidir_port_four_oe & p45_avail;

	// per-bit direction; pull-up register is one bit broadcast
	ppb_bidir_port u_port_five (
		.clk(clk), .sys_rst(sys_rst),
		.wr_data(wr_en && sel == PPB_SEL_P5_DATA),
		.wr_dir(wr_en && sel == PPB_SEL_P5_DIR),
		.wr_pu(wr_en && sel == PPB_SEL_P5_PU),
		.wdata(sel == PPB_SEL_P5_PU ? {8{pwdata[0]}} : pwdata[7:0]),
		.out_only(8'h00), .avail(p45_avail),
		.pin_sync(p5_sync), .pin_out(bidir_port_five_out),
		.pin_oe(bidir_port_five_oe), .pull_en(bidir_port_five_pull_en),
		.latch(p5_latch), .dir(p5_dir), .pu(p5_pu), .rd_value(p5_rd));

	// low nibble forced output, high nibble per-bit
	ppb_bidir_port u_port_six (
		.clk(clk), .sys_rst(sys_rst),
		.wr_data(wr_en && sel == PPB_SEL_P6_DATA),
		.wr_dir(wr_en && sel == PPB_SEL_P6_DIR),
		.wr_pu(wr_en && sel == PPB_SEL_P6_PU),
		.wdata(sel == PPB_SEL_P6_DATA ? pwdata[7:0] : {pwdata[7:4], 4'h0}),
		.out_only(8'h0F), .avail(p6_avail),
		.pin_sync(p6_sync), .pin_out(mixed_port_six_out),
		.pin_oe(mixed_port_six_oe), .pull_en(mixed_port_six_pull_en),
		.latch(p6_latch), .dir(p6_dir), .pu(p6_pu), .rd_value(p6_rd));

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	ppb_byte_t rd_byte;
	ppb_byte_t status;

	// interrupt input level stays visible though the bit is no port bit
	assign status = {6'h00, romless_q, in2_sync[0]};

	assign rd_byte =
		(sel == PPB_SEL_RT_DATA) ? rt_latch :
		(sel == PPB_SEL_RT_CTRL) ? rt_ctrl :
		(sel == PPB_SEL_IN2)     ? {in2_sync[7:1], 1'b0} :
		(sel == PPB_SEL_IN2_PU)  ? {7'h00, in2_pu} :
		(sel == PPB_SEL_P3_DATA) ? p3_rd :
		(sel == PPB_SEL_P3_DIR)  ? p3_dir :
		(sel == PPB_SEL_P3_PU)   ? p3_pu :
		(sel == PPB_SEL_P4_DATA) ? p4_rd :
		(sel == PPB_SEL_P4_CTRL) ? {6'h00, p4_pu_grp, p4_dir[0]} :
		(sel == PPB_SEL_P5_DATA) ? p5_rd :
		(sel == PPB_SEL_P5_DIR)  ? p5_dir :
		(sel == PPB_SEL_P5_PU)   ? {7'h00, p5_pu[0]} :
		(sel == PPB_SEL_P6_DATA) ? p6_rd :
		(sel == PPB_SEL_P6_DIR)  ? (p6_dir | 8'h0F) :
		(sel == PPB_SEL_P6_PU)   ? p6_pu :
		(sel == PPB_SEL_IN7)     ? {2'h0, in7_sync} :
		(sel == PPB_SEL_STATUS)  ? status : 8'h00;

	// read data registered in the setup cycle, valid in the access cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= {24'h000000, rd_byte};
	end

	logic unused_latches;
	assign unused_latches = ^{p3_latch, p4_latch, p5_latch, p6_latch, pwdata[31:8], pstrb[3:1]};

endmodule // ppb_port_bank

/* testbench/ppb_chk.sv */
`include "ppb_regs.svh"

// watches pin drive and pull-ups against register writes
module ppb_chk
(
	// clock and reset
	input wire logic               clk,
	input wire logic               sys_rst,
	// apb requests
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire ppb_pkg::ppb_addr_t paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [3:0]         pstrb,
	// strap and pins
	input wire logic               romless,
	input wire ppb_pkg::ppb_byte_t bidir_port_three_out,
	input wire ppb_pkg::ppb_byte_t bidir_port_three_oe,
	input wire ppb_pkg::ppb_byte_t bidir_port_three_pull_en,
	input wire ppb_pkg::ppb_byte_t bidir_port_four_oe,
	input wire ppb_pkg::ppb_byte_t bidir_port_four_pull_en,
	input wire ppb_pkg::ppb_byte_t bidir_port_five_oe,
	input wire ppb_pkg::ppb_byte_t bidir_port_five_pull_en,
	input wire ppb_pkg::ppb_byte_t mixed_port_six_oe,
	input wire ppb_pkg::ppb_byte_t mixed_port_six_pull_en
);
	timeunit 1ns;
	timeprecision 1ps;
	import ppb_pkg::*;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// ----------------------------------------------------------------
	// sequences
	// ----------------------------------------------------------------
	sequence s_acc;
		psel && penable && pwrite && pstrb[0];
	endsequence
	sequence s_dir_wr;
		s_acc ##0 paddr == `PPB_P3_DIR_OFS;
	endsequence
	sequence s_dat_wr;
		s_acc ##0 paddr == `PPB_P3_DATA_OFS;
	endsequence

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_P3_DIR: assert property (s_dir_wr |=> bidir_port_three_oe == $past(pwdata[7:0]))
		else $error("port three drive differs from written direction");
	AST_P3_LATCH: assert property (s_dat_wr |=>
		bidir_port_three_out == ($past(pwdata[7:0]) & bidir_port_three_oe))
		else $error("port three output differs from written latch");
	AST_P3_PULL: assert property ((bidir_port_three_pull_en & bidir_port_three_oe) == 8'h00)
		else $error("port three pull-up on a driven bit");
	AST_P4_DIR: assert property (bidir_port_four_oe inside {8'h00, 8'hFF})
		else $error("port four bits not switched together");
	AST_P4_PULL: assert property (bidir_port_four_pull_en inside {8'h00, 8'hFF}
		&& (bidir_port_four_pull_en & bidir_port_four_oe) == 8'h00)
		else $error("port four pull-up not a group on inputs");
	AST_P5_PULL: assert property (bidir_port_five_pull_en == 8'h00
		|| bidir_port_five_pull_en == ~bidir_port_five_oe)
		else $error("port five pull-up not on all inputs");
	AST_P6_LOW: assert property (mixed_port_six_pull_en[3:0] == 4'h0
		&& (mixed_port_six_pull_en[7:4] & mixed_port_six_oe[7:4]) == 4'h0)
		else $error("port six pull-up on an output bit");
	AST_ROMLESS: assert property (romless [*5] |-> bidir_port_four_oe == 8'h00
		&& bidir_port_five_oe == 8'h00 && mixed_port_six_oe[5:4] == 2'b00)
		else $error("lost port still driven in romless variant");
	AST_RESET: assert property ($fell(sys_rst) |-> bidir_port_three_oe == 8'h00
		&& bidir_port_five_oe == 8'h00 && bidir_port_three_pull_en == 8'h00)
		else $error("port not released to input after reset");
endmodule // ppb_chk

/* testbench/ppb_pins.sv */
// pins outside one port: drive wins, then pull-up, then a weak source
module ppb_pins
(
	// port side
	input wire logic [7:0] out,
	input wire logic [7:0] oe,
	input wire logic [7:0] pull_en,
	// outside source and level seen
	input wire logic [7:0] ext,
	output logic     [7:0] pin
);
	timeunit 1ns;
	timeprecision 1ps;

	always_comb
		for (int b = 0; b < 8; b++)
			pin[b] = oe[b] ? out[b] : (pull_en[b] ? 1'b1 : ext[b]);
endmodule // ppb_pins

/* testbench/tb_top.sv */
`include "ppb_regs.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ppb_pkg::*;

	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	ppb_addr_t   paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        romless = 1'b0;
	logic        rt_low_trig = 1'b0;
	logic        rt_high_trig = 1'b0;
	ppb_byte_t   rt_output_port, rt_output_port_oe;
	ppb_byte_t   input_port_two = 8'h00;
	logic [5:0]  upper_six_input_bits_pull_en;
	logic [5:0]  analog_shared_input_port = 6'h00;
	ppb_byte_t   bidir_port_three_in, bidir_port_three_out, bidir_port_three_oe;
	ppb_byte_t   bidir_port_four_in, bidir_port_four_out, bidir_port_four_oe;
	ppb_byte_t   bidir_port_five_in, bidir_port_five_out, bidir_port_five_oe;
	ppb_byte_t   mixed_port_six_in, mixed_port_six_out, mixed_port_six_oe;
	ppb_byte_t   bidir_port_three_pull_en, bidir_port_four_pull_en;
	ppb_byte_t   bidir_port_five_pull_en, mixed_port_six_pull_en;
	ppb_byte_t   x3 = 8'h00;
	ppb_byte_t   x4 = 8'h00;
	int          n_mismatch = 0;
	int          n_tests = 0;

	always #5 clk = ~clk;

	ppb_port_bank dut (.*);
	ppb_pins u_p3 (.out(bidir_port_three_out), .oe(bidir_port_three_oe),
		.pull_en(bidir_port_three_pull_en), .ext(x3), .pin(bidir_port_three_in));
	ppb_pins u_p4 (.out(bidir_port_four_out), .oe(bidir_port_four_oe),
		.pull_en(bidir_port_four_pull_en), .ext(x4), .pin(bidir_port_four_in));
	ppb_pins u_p5 (.out(bidir_port_five_out), .oe(bidir_port_five_oe),
		.pull_en(bidir_port_five_pull_en), .ext(8'h00), .pin(bidir_port_five_in));
	ppb_pins u_p6 (.out(mixed_port_six_out), .oe(mixed_port_six_oe),
		.pull_en(mixed_port_six_pull_en), .ext(8'h00), .pin(mixed_port_six_in));

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input ppb_byte_t ex, input ppb_byte_t got);
		n_tests++;
		if (got !== ex)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// one apb transfer; waits for pready with a bound
	task automatic apb(input logic w, input ppb_addr_t a, input ppb_byte_t d,
		output ppb_byte_t rd, output logic err);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16)
		begin
			n_mismatch++;
			results();
		end
	endtask

	task automatic wr(input ppb_addr_t a, input ppb_byte_t d);
		ppb_byte_t r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rdc(input string nm, input ppb_addr_t a, input ppb_byte_t ex);
		ppb_byte_t r;
		logic e;
		apb(1'b0, a, 8'h00, r, e);
		chk(nm, ex, r);
	endtask

	task automatic errc(input string nm, input logic w, input ppb_addr_t a);
		ppb_byte_t r;
		logic e;
		apb(w, a, 8'hFF, r, e);
		chk(nm, 8'h01, {7'h0, e});
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic t_reset();
		wt(0);
		chk("p3 oe", 8'h00, bidir_port_three_oe);
		chk("rt oe", 8'h00, rt_output_port_oe);
		chk("p4 pull", 8'h00, bidir_port_four_pull_en);
		rdc("p3 dir", `PPB_P3_DIR_OFS, 8'h00);
		rdc("p5 pu", `PPB_P5_PU_OFS, 8'h00);
		rdc("p6 dir", `PPB_P6_DIR_OFS, 8'h0F);
		$display("reset test done");
	endtask

	task automatic t_port3();
		@(posedge clk);
		x3 <= 8'h30;
		wr(`PPB_P3_DATA_OFS, 8'hA5);
		wt(0);
		chk("p3 out", 8'h00, bidir_port_three_out);
		wr(`PPB_P3_DIR_OFS, 8'h0F);
		wt(0);
		chk("p3 oe", 8'h0F, bidir_port_three_oe);
		chk("p3 out", 8'h05, bidir_port_three_out);
		wr(`PPB_P3_PU_OFS, 8'hFF);
		wt(3);
		chk("p3 pull", 8'hF0, bidir_port_three_pull_en);
		rdc("p3 read", `PPB_P3_DATA_OFS, 8'hF5);
		wr(`PPB_P3_PU_OFS, 8'h00);
		wt(3);
		rdc("p3 read", `PPB_P3_DATA_OFS, 8'h35);
		// lane 0 strobe low: the write must be dropped
		@(posedge clk);
		pstrb <= 4'hE;
		wr(`PPB_P3_DIR_OFS, 8'hFF);
		pstrb <= 4'hF;
		rdc("p3 dir", `PPB_P3_DIR_OFS, 8'h0F);
		$display("port three test done");
	endtask

	task automatic t_port456();
		@(posedge clk);
		x4 <= 8'h0F;
		wr(`PPB_P4_DATA_OFS, 8'h5A);
		wr(`PPB_P4_CTRL_OFS, 8'h02);
		wt(3);
		chk("p4 oe", 8'h00, bidir_port_four_oe);
		rdc("p4 read", `PPB_P4_DATA_OFS, 8'hFF);
		wr(`PPB_P4_CTRL_OFS, 8'h03);
		wt(0);
		chk("p4 oe", 8'hFF, bidir_port_four_oe);
		chk("p4 pull", 8'h00, bidir_port_four_pull_en);
		chk("p4 out", 8'h5A, bidir_port_four_out);
		wr(`PPB_P5_DIR_OFS, 8'hF0);
		wr(`PPB_P5_PU_OFS, 8'h01);
		wt(0);
		chk("p5 oe", 8'hF0, bidir_port_five_oe);
		chk("p5 pull", 8'h0F, bidir_port_five_pull_en);
		wr(`PPB_P6_DIR_OFS, 8'h5F);
		wr(`PPB_P6_PU_OFS, 8'hFF);
		wt(0);
		chk("p6 oe", 8'h50, {mixed_port_six_oe[7:4], 4'h0});
		chk("p6 pull", 8'hA0, mixed_port_six_pull_en);
		rdc("p6 dir", `PPB_P6_DIR_OFS, 8'h5F);
		wr(`PPB_P5_DATA_OFS, 8'hA5);
		wr(`PPB_P6_DATA_OFS, 8'h3C);
		wt(3);
		chk("p5 out", 8'hA0, bidir_port_five_out);
		chk("p6 out", 8'h1C, mixed_port_six_out);
		rdc("p5 read", `PPB_P5_DATA_OFS, 8'hAF);
		rdc("p6 read", `PPB_P6_DATA_OFS, 8'hBC);
		$display("ports four to six test done");
	endtask

	task automatic t_in2();
		wr(`PPB_IN2_PU_OFS, 8'h01);
		wt(0);
		chk("p2 pull", 8'h3F, {2'b00, upper_six_input_bits_pull_en});
		@(posedge clk);
		input_port_two <= 8'hA5;
		analog_shared_input_port <= 6'h2A;
		wt(3);
		rdc("p2 read", `PPB_IN2_DATA_OFS, 8'hA4);
		rdc("p7 read", `PPB_IN7_DATA_OFS, 8'h2A);
		rdc("nmi level", `PPB_STATUS_OFS, 8'h01);
		@(posedge clk);
		input_port_two <= 8'h5A;
		wt(3);
		rdc("p2 read", `PPB_IN2_DATA_OFS, 8'h5A);
		rdc("nmi level", `PPB_STATUS_OFS, 8'h00);
		errc("read-only write", 1'b1, `PPB_IN2_DATA_OFS);
		errc("unmapped read", 1'b0, 12'h100);
		$display("input port test done");
	endtask

	task automatic t_rt();
		wr(`PPB_RT_CTRL_OFS, 8'h01);
		wr(`PPB_RT_DATA_OFS, 8'h3C);
		wt(0);
		chk("rt oe", 8'hFF, rt_output_port_oe);
		chk("rt out", 8'h3C, rt_output_port);
		wr(`PPB_RT_CTRL_OFS, 8'h07);
		wr(`PPB_RT_DATA_OFS, 8'hA5);
		wt(0);
		chk("rt held", 8'h3C, rt_output_port);
		@(posedge clk);
		rt_low_trig <= 1'b1;
		@(posedge clk);
		rt_low_trig <= 1'b0;
		wt(0);
		chk("rt low", 8'h35, rt_output_port);
		@(posedge clk);
		rt_high_trig <= 1'b1;
		@(posedge clk);
		rt_high_trig <= 1'b0;
		wt(0);
		chk("rt high", 8'hA5, rt_output_port);
		$display("realtime test done");
	endtask

	task automatic t_rom();
		@(posedge clk);
		romless <= 1'b1;
		wt(6);
		chk("p4 oe", 8'h00, bidir_port_four_oe);
		chk("p5 oe", 8'h00, bidir_port_five_oe);
		chk("strobes", 8'h00, {6'h0, mixed_port_six_oe[5:4]});
		rdc("status", `PPB_STATUS_OFS, 8'h02);
		rdc("p4 read", `PPB_P4_DATA_OFS, 8'h00);
		@(posedge clk);
		romless <= 1'b0;
		wt(6);
		chk("p4 oe", 8'hFF, bidir_port_four_oe);
		$display("romless test done");
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_port3();
		t_port456();
		t_in2();
		t_rt();
		t_rom();
		results();
	end
endmodule // tb_top

bind ppb_port_bank ppb_chk u_chk (.*);
